// ==== irq_pick.sv ====
// fixed priority pick of the lowest pending unmasked source
`timescale 1ns/100ps
module irq_pick #(
  parameter int N = 16,
  parameter int IW = 4
) (
  input wire logic [N-1:0] pend_in,
  output logic valid_out,
  output logic [IW-1:0] idx_out
);
  always_comb begin
    valid_out = 1'b0;
    idx_out = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pend_in[i]) begin
        valid_out = 1'b1;
        idx_out = IW'(i);
      end
    end
  end
endmodule // irq_pick

// ==== settle_timer.sv ====
// down counter for settling and pause waits
`timescale 1ns/100ps
module settle_timer (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  wait_if.tmr w
);
  logic [standby_pkg::CNT_W-1:0] cnt;
  logic busy;
  wire at_zero = (cnt == '0);

  // done is one pulse, load+1 cycles after start
  assign w.done = busy && at_zero;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= '0;
      busy <= 1'b0;
    end else if (w.start) begin
      cnt <= w.load;
      busy <= 1'b1;
    end else if (busy) begin
      cnt <= at_zero ? cnt : cnt - 1'b1;
      busy <= !at_zero;
    end
  end
endmodule // settle_timer

// ==== standby_cpu_partner.sv ====
// oscillator and cpu model facing the standby controller
`timescale 1ns/100ps
module standby_cpu_partner #(
  parameter int OSC_DLY = 6
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic osc_en_in,
  input wire logic irq_req_in,
  input wire logic [3:0] irq_idx_in,
  input wire logic ack_en_in,
  input wire logic [3:0] ack_lat_in,
  output logic osc_running_out,
  output logic irq_ack_out,
  output logic [3:0] irq_ack_idx_out
);
  logic [3:0] osc_cnt;
  logic [3:0] lat_cnt;
  // start-up gap the controller must not count as settle time
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      osc_cnt <= 4'h0;
      osc_running_out <= 1'b0;
      lat_cnt <= 4'h0;
      irq_ack_out <= 1'b0;
      irq_ack_idx_out <= 4'h0;
    end else begin
      osc_cnt <= osc_en_in ? osc_cnt + {3'h0, osc_cnt != OSC_DLY[3:0]} : 4'h0;
      osc_running_out <= osc_en_in && osc_cnt == OSC_DLY[3:0];
      irq_ack_out <= 1'b0;
      if (irq_ack_out || !irq_req_in || !ack_en_in) begin
        lat_cnt <= 4'h0;
      end else if (lat_cnt == ack_lat_in) begin
        irq_ack_out <= 1'b1;
        irq_ack_idx_out <= irq_idx_in;
      end else begin
        lat_cnt <= lat_cnt + 4'h1;
      end
    end
  end
endmodule // standby_cpu_partner

// ==== standby_pkg.sv ====
// constants, register map and mode encoding for the standby and wake controller
package standby_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IRQ_N = 16;
  localparam int IRQ_IDX_W = 4;
  localparam int REG_W = 8;
  localparam int CNT_W = 18;
  localparam int SEL_W = 3;
  localparam int EVT_W = 4;

  localparam logic [ADDR_W-1:0] OFF_FLAG0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_FLAG1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_MASK0 = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_MASK1 = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_SETTLE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CLKCTL = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_EVT = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_EVT_MASK = 8'h20;

  localparam logic [REG_W-1:0] RST_FLAG = 8'h00;
  localparam logic [REG_W-1:0] RST_MASK = 8'hFF;
  localparam logic [SEL_W-1:0] RST_SETTLE = 3'h0;
  localparam logic [EVT_W-1:0] RST_EVT = 4'h0;

  // clk control and status field positions
  localparam int BIT_SLOW_HALT = 0;
  localparam int BIT_ST_SLOW_RUN = 3;
  localparam int BIT_ST_STOPPABLE = 4;

  // event bits
  localparam int EV_HALT_WAKE = 0;
  localparam int EV_STOP_WAKE = 1;
  localparam int EV_RESUME = 2;
  localparam int EV_HELD = 3;

  // timing
  localparam int PAUSE_US = 34;
  localparam int CLK_MHZ = 250;
  localparam int PAUSE_CYC = PAUSE_US * CLK_MHZ;
  localparam int SETTLE_BASE = 10;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_HALT = 3'b001,
    ST_STOP = 3'b010,
    ST_OSC = 3'b011,
    ST_SETTLE = 3'b100,
    ST_PAUSE = 3'b101
  } mode_e;
endpackage

// ==== standby_wake_control.sv ====
// standby entry, wake-up, settle sequencing and interrupt flag handling
// Notes on behaviour
// - hold requests while flag or mask accessed
// - new request raised even during servicing
// - slow oscillator stop only when option allows
// - running slow oscillator keeps running in stop
// - settle count starts after oscillation begins
// - settle after reset taken from option
// - pending unmasked request ends halt at once
// - stop wake: settle in crystal mode only, then fixed pause
`timescale 1ns/100ps
module standby_wake_control #(
  parameter int PAUSE_CYCLES = standby_pkg::PAUSE_CYC,
  parameter int SETTLE_BASE = standby_pkg::SETTLE_BASE
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [standby_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [standby_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [standby_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic halt_cmd_in,
  input wire logic stop_cmd_in,
  input wire logic [standby_pkg::IRQ_N-1:0] irq_src_in,
  input wire logic irq_ack_in,
  input wire logic [standby_pkg::IRQ_IDX_W-1:0] irq_ack_idx_in,
  output logic irq_req_out,
  output logic [standby_pkg::IRQ_IDX_W-1:0] irq_idx_out,
  input wire logic osc_running_in,
  input wire logic crystal_mode_in,
  input wire logic opt_slow_stoppable_in,
  input wire logic [standby_pkg::SEL_W-1:0] opt_settle_sel_in,
  output logic osc_en_out,
  output logic sys_clk_en_out,
  output logic cpu_clk_en_out,
  output logic slow_osc_en_out,
  output logic [2:0] mode_out,
  output logic event_irq_out
);
  localparam int RW = standby_pkg::REG_W;
  localparam int N = standby_pkg::IRQ_N;
  localparam int EW = standby_pkg::EVT_W;
  localparam int CW = standby_pkg::CNT_W;
  localparam int SW = standby_pkg::SEL_W;
  localparam logic [EW-1:0] RST_EVT_MASK = standby_pkg::RST_EVT;

  // register bus decode
  wire sel_flag0 = (reg_addr_in == standby_pkg::OFF_FLAG0);
  wire sel_flag1 = (reg_addr_in == standby_pkg::OFF_FLAG1);
  wire sel_mask0 = (reg_addr_in == standby_pkg::OFF_MASK0);
  wire sel_mask1 = (reg_addr_in == standby_pkg::OFF_MASK1);
  wire sel_settle = (reg_addr_in == standby_pkg::OFF_SETTLE);
  wire sel_clkctl = (reg_addr_in == standby_pkg::OFF_CLKCTL);
  wire sel_status = (reg_addr_in == standby_pkg::OFF_STATUS);
  wire sel_evt = (reg_addr_in == standby_pkg::OFF_EVT);
  wire sel_evt_mask = (reg_addr_in == standby_pkg::OFF_EVT_MASK);
  wire wr_flag0 = reg_wr_in && sel_flag0;
  wire wr_flag1 = reg_wr_in && sel_flag1;
  wire wr_mask0 = reg_wr_in && sel_mask0;
  wire wr_mask1 = reg_wr_in && sel_mask1;
  wire wr_settle = reg_wr_in && sel_settle;
  wire wr_clkctl = reg_wr_in && sel_clkctl;
  wire wr_evt = reg_wr_in && sel_evt;
  wire wr_evt_mask = reg_wr_in && sel_evt_mask;
  wire [RW-1:0] wbyte = reg_wdata_in[RW-1:0];

  wire flag_access = (reg_wr_in || reg_rd_in) &&
                     (sel_flag0 || sel_flag1 || sel_mask0 || sel_mask1);

  // registers
  logic [RW-1:0] irq_flag_reg_0;
  logic [RW-1:0] irq_flag_reg_1;
  logic [RW-1:0] irq_mask_reg_0;
  logic [RW-1:0] irq_mask_reg_1;
  logic [SW-1:0] osc_settle_select;
  logic slow_osc_halt_bit;
  logic [EW-1:0] evt_status;
  logic [EW-1:0] evt_mask;
  logic [standby_pkg::DATA_W-1:0] rdata;

  // option straps caught after release
  logic strap_taken;
  logic opt_stoppable;
  logic [SW-1:0] opt_settle_sel;

  // interrupt flag state, per source
  wire [N-1:0] flags = {irq_flag_reg_1, irq_flag_reg_0};
  wire [N-1:0] masks = {irq_mask_reg_1, irq_mask_reg_0};
  wire [N-1:0] pend = flags & ~masks;
  wire [N-1:0] ack_hit;
  wire [N-1:0] sw_wr;
  wire [N-1:0] next_flags;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_flag
      assign ack_hit[g] = irq_ack_in && (irq_ack_idx_in == standby_pkg::IRQ_IDX_W'(g));
      assign sw_wr[g] = (g < RW) ? wr_flag0 : wr_flag1;
      // a new request wins over software clear and ack
      assign next_flags[g] = irq_src_in[g] ||
                             (sw_wr[g] ? wbyte[g % RW] : (flags[g] && !ack_hit[g]));
    end
  endgenerate

  // priority select
  logic pick_valid;
  logic [standby_pkg::IRQ_IDX_W-1:0] pick_idx;
  irq_pick #(
    .N(N),
    .IW(standby_pkg::IRQ_IDX_W)
  ) u_pick (
    .pend_in(pend),
    .valid_out(pick_valid),
    .idx_out(pick_idx)
  );

  // wake condition seen by both standby modes
  wire wake_any = |pend;

  // sequencer
  standby_pkg::mode_e mode;
  standby_pkg::mode_e next_mode;
  logic from_reset;
  logic req_q;
  logic [standby_pkg::IRQ_IDX_W-1:0] idx_q;

  wait_if w ();
  settle_timer u_timer (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .w(w)
  );

  wire [SW-1:0] settle_sel = from_reset ? opt_settle_sel : osc_settle_select;
  wire [CW-1:0] settle_load = CW'((1 << (SETTLE_BASE + int'(settle_sel))) - 1);
  wire [CW-1:0] pause_load = CW'(PAUSE_CYCLES - 1);
  // crystal needs the settle wait; after reset settle is always applied
  wire need_settle = crystal_mode_in || from_reset;

  wire osc_go = (mode == standby_pkg::ST_OSC) && osc_running_in && strap_taken;
  // settle count only after oscillation start
  wire start_settle = osc_go && need_settle;
  wire start_pause_direct = osc_go && !need_settle && !from_reset;
  wire settle_end = (mode == standby_pkg::ST_SETTLE) && w.done;
  // fixed pause follows settle on stop wake
  wire start_pause = start_pause_direct || (settle_end && !from_reset);
  assign w.start = start_settle || start_pause;
  assign w.load = start_settle ? settle_load : pause_load;

  always_comb begin
    next_mode = mode;
    case (mode)
      standby_pkg::ST_RUN: begin
        if (halt_cmd_in && !wake_any) begin
          next_mode = standby_pkg::ST_HALT;
        end else if (stop_cmd_in && !wake_any) begin
          next_mode = standby_pkg::ST_STOP;
        end
      end
      standby_pkg::ST_HALT: begin
        if (wake_any) begin
          next_mode = standby_pkg::ST_RUN;
        end
      end
      standby_pkg::ST_STOP: begin
        if (wake_any) begin
          next_mode = standby_pkg::ST_OSC;
        end
      end
      standby_pkg::ST_OSC: begin
        if (start_settle) begin
          next_mode = standby_pkg::ST_SETTLE;
        end else if (start_pause_direct) begin
          next_mode = standby_pkg::ST_PAUSE;
        end else if (osc_go) begin
          next_mode = standby_pkg::ST_RUN;
        end
      end
      standby_pkg::ST_SETTLE: begin
        if (settle_end) begin
          next_mode = from_reset ? standby_pkg::ST_RUN : standby_pkg::ST_PAUSE;
        end
      end
      standby_pkg::ST_PAUSE: begin
        if (w.done) begin
          next_mode = standby_pkg::ST_RUN;
        end
      end
      default: next_mode = standby_pkg::ST_RUN;
    endcase
  end

  wire resume = (next_mode == standby_pkg::ST_RUN) && (mode != standby_pkg::ST_RUN) &&
                (mode != standby_pkg::ST_HALT);

  // event sources
  wire [EW-1:0] evt_set;
  assign evt_set[standby_pkg::EV_HALT_WAKE] = (mode == standby_pkg::ST_HALT) && wake_any;
  assign evt_set[standby_pkg::EV_STOP_WAKE] = (mode == standby_pkg::ST_STOP) && wake_any;
  assign evt_set[standby_pkg::EV_RESUME] = resume;
  assign evt_set[standby_pkg::EV_HELD] = flag_access && pick_valid;
  // set wins over write-one-clear
  wire [EW-1:0] next_evt = evt_set | (evt_status & ~(wr_evt ? wbyte[EW-1:0] : '0));

  // no in-service blocking, any pending request is offered
  wire next_req = pick_valid && !irq_ack_in;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode <= standby_pkg::ST_OSC;
      from_reset <= 1'b1;
      req_q <= 1'b0;
      idx_q <= '0;
    end else begin
      mode <= next_mode;
      from_reset <= from_reset && (mode != standby_pkg::ST_RUN);
      req_q <= next_req;
      idx_q <= pick_idx;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_taken <= 1'b0;
      opt_stoppable <= 1'b0;
      opt_settle_sel <= standby_pkg::RST_SETTLE;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      opt_stoppable <= opt_slow_stoppable_in;
      opt_settle_sel <= opt_settle_sel_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_flag_reg_0 <= standby_pkg::RST_FLAG;
      irq_flag_reg_1 <= standby_pkg::RST_FLAG;
    end else begin
      irq_flag_reg_0 <= next_flags[RW-1:0];
      irq_flag_reg_1 <= next_flags[N-1:RW];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_mask_reg_0 <= standby_pkg::RST_MASK;
      irq_mask_reg_1 <= standby_pkg::RST_MASK;
      osc_settle_select <= standby_pkg::RST_SETTLE;
      slow_osc_halt_bit <= 1'b0;
      evt_mask <= RST_EVT_MASK;
      evt_status <= standby_pkg::RST_EVT;
    end else begin
      if (wr_mask0) irq_mask_reg_0 <= wbyte;
      if (wr_mask1) irq_mask_reg_1 <= wbyte;
      if (wr_settle) osc_settle_select <= wbyte[SW-1:0];
      if (wr_clkctl) slow_osc_halt_bit <= wbyte[standby_pkg::BIT_SLOW_HALT];
      if (wr_evt_mask) evt_mask <= wbyte[EW-1:0];
      evt_status <= next_evt;
    end
  end

  // read mux, unmapped reads return zero
  wire [standby_pkg::DATA_W-1:0] status_word;
  assign status_word = {
    {(standby_pkg::DATA_W - 5){1'b0}},
    opt_stoppable,
    slow_osc_en_out,
    mode
  };
  wire [standby_pkg::DATA_W-1:0] rd_mux =
    sel_flag0 ? {{(standby_pkg::DATA_W - RW){1'b0}}, irq_flag_reg_0} :
    sel_flag1 ? {{(standby_pkg::DATA_W - RW){1'b0}}, irq_flag_reg_1} :
    sel_mask0 ? {{(standby_pkg::DATA_W - RW){1'b0}}, irq_mask_reg_0} :
    sel_mask1 ? {{(standby_pkg::DATA_W - RW){1'b0}}, irq_mask_reg_1} :
    sel_settle ? {{(standby_pkg::DATA_W - SW){1'b0}}, osc_settle_select} :
    sel_clkctl ? {{(standby_pkg::DATA_W - 1){1'b0}}, slow_osc_halt_bit} :
    sel_status ? status_word :
    sel_evt ? {{(standby_pkg::DATA_W - EW){1'b0}}, evt_status} :
    sel_evt_mask ? {{(standby_pkg::DATA_W - EW){1'b0}}, evt_mask} :
    '0;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata <= '0;
    end else begin
      rdata <= reg_rd_in ? rd_mux : '0;
    end
  end

  assign reg_rdata_out = rdata;

  // request withheld during flag or mask access
  assign irq_req_out = req_q && !flag_access;
  assign irq_idx_out = idx_q;

  wire in_stop = (mode == standby_pkg::ST_STOP);
  wire waking = (mode == standby_pkg::ST_OSC) || (mode == standby_pkg::ST_SETTLE) ||
                (mode == standby_pkg::ST_PAUSE);
  assign osc_en_out = !in_stop;
  assign sys_clk_en_out = !in_stop && !waking;
  assign cpu_clk_en_out = (mode == standby_pkg::ST_RUN);

  // stop bit honoured only when option permits
  // stop mode itself never stops the slow oscillator
  assign slow_osc_en_out = !(opt_stoppable && slow_osc_halt_bit);

  assign mode_out = mode;
  assign event_irq_out = |(evt_status & ~evt_mask);
endmodule // standby_wake_control

// ==== standby_wake_control_monitor.sv ====
// assertion checker on the standby and wake controller ports
`timescale 1ns/100ps
module standby_wake_monitor #(
  parameter int PAUSE_CYCLES = standby_pkg::PAUSE_CYC,
  parameter int SETTLE_BASE = standby_pkg::SETTLE_BASE
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [standby_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic irq_req_out,
  input wire logic osc_running_in,
  input wire logic opt_slow_stoppable_in,
  input wire logic osc_en_out,
  input wire logic sys_clk_en_out,
  input wire logic cpu_clk_en_out,
  input wire logic slow_osc_en_out,
  input wire logic [2:0] mode_out
);
  logic [19:0] pause_cnt;
  logic [19:0] settle_cnt;
  wire flag_access = (reg_wr_in || reg_rd_in) && reg_addr_in < 8'h10 && reg_addr_in[1:0] == 2'h0;
  default clocking mon_cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // cycles spent in the current pause or settle stretch
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pause_cnt <= 20'h0_0000;
      settle_cnt <= 20'h0_0000;
    end else begin
      pause_cnt <= (mode_out == 3'h5) ? pause_cnt + 20'h0_0001 : 20'h0_0000;
      settle_cnt <= (mode_out == 3'h4) ? settle_cnt + 20'h0_0001 : 20'h0_0000;
    end
  end
  a_held_on_access: assert property (flag_access |-> !irq_req_out)
    else $error("request offered during flag or mask access");
  a_halt_cpu_gated: assert property (mode_out == 3'h1 |-> sys_clk_en_out && !cpu_clk_en_out)
    else $error("halt clock gating wrong");
  a_stop_sys_gated: assert property (mode_out == 3'h2 |-> !sys_clk_en_out && !osc_en_out)
    else $error("stop left a clock running");
  a_slow_halt_opt: assert property (!slow_osc_en_out |-> opt_slow_stoppable_in)
    else $error("slow oscillator stopped without option");
  a_slow_kept_stop: assert property (mode_out == 3'h2 |-> $stable(slow_osc_en_out))
    else $error("slow oscillator changed in stop");
  a_wait_for_osc: assert property (mode_out == 3'h3 && !osc_running_in |=> mode_out == 3'h3)
    else $error("wait started before oscillation");
  a_halt_ends_pend: assert property (irq_req_out |-> mode_out != 3'h1)
    else $error("halt held with request offered");
  a_pause_bounded: assert property (mode_out == 3'h5 |-> int'(pause_cnt) <= PAUSE_CYCLES + 1)
    else $error("pause overran");
  a_pause_full: assert property ($past(mode_out) == 3'h5 && mode_out != 3'h5
      |-> int'($past(pause_cnt)) >= PAUSE_CYCLES - 1)
    else $error("pause cut short");
  a_settle_full: assert property ($past(mode_out) == 3'h4 && mode_out != 3'h4
      |-> int'($past(settle_cnt)) >= (1 << SETTLE_BASE) - 1)
    else $error("settle cut short");
endmodule // standby_wake_monitor

bind standby_wake_control standby_wake_monitor #(.PAUSE_CYCLES(PAUSE_CYCLES),
  .SETTLE_BASE(SETTLE_BASE)) mon (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .irq_req_out(irq_req_out), .osc_running_in(osc_running_in),
  .opt_slow_stoppable_in(opt_slow_stoppable_in), .osc_en_out(osc_en_out),
  .sys_clk_en_out(sys_clk_en_out), .cpu_clk_en_out(cpu_clk_en_out),
  .slow_osc_en_out(slow_osc_en_out), .mode_out(mode_out));

// ==== standby_wake_control_tb_top.sv ====
// self-checking bench for the standby and wake controller
`timescale 1ns/100ps
module standby_wake_control_tb_top;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, halt = 0, stop = 0, xtal = 1, opt_stop = 0;
  logic ack_en = 0, ack, req, osc_run, osc_en, sys_en, cpu_en, slow_en, ev_irq;
  logic [7:0] a = 8'h00;
  logic [31:0] wd = 32'h0000_0000, rdat, d, r = 32'h2f4b_0a5e;
  logic [15:0] src = 16'h0000;
  logic [3:0] lat = 4'h3, ack_idx, idx;
  logic [2:0] sel = 3'h2, mode;
  logic [7:0] ads [6] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h40};
  logic [7:0] exs [6] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
  logic [3:0] ackq [$];
  int fails = 0, check_count = 0, n;
  always #2 clk = ~clk;
  always @(posedge clk) if (ack) ackq.push_back(ack_idx);
  standby_wake_control #(.PAUSE_CYCLES(20), .SETTLE_BASE(2)) uut (.ref_clk_in(clk),
    .rst_n_in(rst_n), .reg_addr_in(a), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdat), .halt_cmd_in(halt), .stop_cmd_in(stop), .irq_src_in(src),
    .irq_ack_in(ack), .irq_ack_idx_in(ack_idx), .irq_req_out(req), .irq_idx_out(idx),
    .osc_running_in(osc_run), .crystal_mode_in(xtal), .opt_slow_stoppable_in(opt_stop),
    .opt_settle_sel_in(sel), .osc_en_out(osc_en), .sys_clk_en_out(sys_en),
    .cpu_clk_en_out(cpu_en), .slow_osc_en_out(slow_en), .mode_out(mode),
    .event_irq_out(ev_irq));
  standby_cpu_partner cpu (.ref_clk_in(clk), .rst_n_in(rst_n), .osc_en_in(osc_en),
    .irq_req_in(req), .irq_idx_in(idx), .ack_en_in(ack_en), .ack_lat_in(lat),
    .osc_running_out(osc_run), .irq_ack_out(ack), .irq_ack_idx_out(ack_idx));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic int settle_len(input logic [2:0] v);
    return 1 << (2 + v);
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] ad, input logic [31:0] v);
    @(posedge clk);
    a <= ad;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] ad, output logic [31:0] v);
    @(posedge clk);
    a <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdat;
  endtask
  task automatic pulse(input logic [15:0] v);
    @(posedge clk);
    src <= v;
    @(posedge clk);
    src <= 16'h0000;
  endtask
  task automatic cmd(input logic h);
    @(posedge clk);
    halt <= h;
    stop <= !h;
    @(posedge clk);
    halt <= 1'b0;
    stop <= 1'b0;
    #1;
  endtask
  // counts settle cycles on the way, bounded
  task automatic wait_mode(input logic [2:0] m);
    int i;
    i = 0;
    n = 0;
    while (mode !== m && i < 3000) begin
      @(posedge clk);
      #1 i++;
      if (mode === 3'h4) n++;
    end
    check(mode, m);
  endtask
  task automatic do_reset(input logic s, input logic [2:0] v, input int hold);
    rst_n <= 1'b0;
    opt_stop <= s;
    sel <= v;
    repeat (hold) @(posedge clk);
    rst_n <= 1'b1;
    wait_mode(3'h0);
    check(n >= settle_len(v) && n <= settle_len(v) + 1, 1);
  endtask
  task automatic complete_run;
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    do_reset(1'b0, 3'h2, 8);
    rd_reg(8'h18, d);
    check(d, 32'h0000_0008);
    for (int k = 0; k < 6; k++) begin
      rd_reg(ads[k], d);
      check(d, {24'h00_0000, exs[k]});
    end
    wr_reg(8'h14, 32'h0000_0001);
    check(slow_en, 1'b1);
    for (int k = 0; k < 6; k++) begin
      r = lfsr(r);
      wr_reg(8'h10, r);
      rd_reg(8'h10, d);
      check(d, {29'h0000_0000, r[2:0]});
    end
    wr_reg(8'h08, 32'h0000_00D7);
    pulse(16'h0028);
    rd_reg(8'h00, d);
    check(d, 32'h0000_0028);
    ack_en <= 1'b1;
    for (int k = 0; k < 60 && ackq.size() < 2; k++) @(posedge clk);
    check({ackq[0], ackq[1]}, 8'h35);
    ack_en <= 1'b0;
    pulse(16'h0008);
    repeat (3) @(posedge clk);
    cmd(1'b1);
    check(mode, 3'h0);
    ack_en <= 1'b1;
    for (int k = 0; k < 60 && ackq.size() < 3; k++) @(posedge clk);
    repeat (3) @(posedge clk);
    cmd(1'b1);
    check({sys_en, cpu_en, mode}, 5'h11);
    pulse(16'h0020);
    wait_mode(3'h0);
    rd_reg(8'h1C, d);
    check({d[2], d[0], ev_irq}, 3'h7);
    wr_reg(8'h20, 32'h0000_000F);
    check(ev_irq, 1'b0);
    wr_reg(8'h20, 32'h0000_0000);
    wr_reg(8'h1C, 32'h0000_000F);
    check(ev_irq, 1'b0);
    lat <= 4'h1;
    for (int c = 0; c < 2; c++) begin
      xtal <= c[0];
      wr_reg(8'h10, 32'h0000_0001);
      cmd(1'b0);
      check({slow_en, mode}, 4'hA);
      pulse(16'h0008);
      wait_mode(3'h0);
      check(n >= c * settle_len(3'h1) && n <= c * (settle_len(3'h1) + 1), 1);
      rd_reg(8'h1C, d);
      check(d[1], 1'b1);
    end
    cmd(1'b0);
    pulse(16'h0008);
    wait_mode(3'h5);
    do_reset(1'b1, 3'h0, 500);
    wr_reg(8'h14, 32'h0000_0001);
    rd_reg(8'h18, d);
    check({slow_en, d[4:3]}, 3'h2);
    complete_run;
  end
  initial begin
    #160000;
    fails++;
    complete_run;
  end
endmodule // standby_wake_control_tb_top

// ==== wait_if.sv ====
// handshake between the sequencer and its wait timer
`timescale 1ns/100ps
interface wait_if;
  logic start;
  logic [standby_pkg::CNT_W-1:0] load;
  logic done;
  modport ctl (output start, output load, input done);
  modport tmr (input start, input load, output done);
endinterface // wait_if
